// ### verilog/irq_seq_pkg.sv
// constants for the interrupt accept and return sequencer
package irq_seq_pkg;

    // ****************************************
    // sources and priorities
    // ****************************************
    localparam logic [3:0] SRC_SWI = 4'h1;
    localparam logic [3:0] SRC_WDT = 4'h2;
    localparam logic [3:0] SRC_EXT_IRQ_ZERO = 4'h3;
    localparam logic [15:0] VEC_TOP = 16'hfffe;

    // ****************************************
    // stack and status word
    // ****************************************
    localparam logic [15:0] SP_STEP1 = 16'h0001;
    localparam logic [15:0] SP_STEP2 = 16'h0002;
    localparam logic [15:0] SP_STEP3 = 16'h0003;
    localparam int unsigned RBS_LSB = 0;
    localparam int unsigned RBS_W = 4;

    // ****************************************
    // fetch memory map
    // ****************************************
    localparam logic [15:0] RAM_SFR_END = 16'h083f;
    localparam logic [15:0] TEST_LO = 16'h1080;
    localparam logic [15:0] TEST_HI = 16'h10ff;
    localparam logic [15:0] ROM_BASE = 16'h8000;
    localparam logic [7:0] FILL_BYTE = 8'hff;

    // ****************************************
    // sequencer states
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE, ST_ACK, ST_GAP, ST_PSW, ST_PCH, ST_PCL,
        ST_VLO, ST_VHI, ST_JUMP, ST_RPCL, ST_RPCH, ST_RPSW
    } seq_state_t;

    // vector table address of a source
    function automatic logic [15:0] vec_addr(input logic [3:0] idx);
        return VEC_TOP - {11'h000, idx, 1'b0};
    endfunction

endpackage

// ### verilog/irq_sel_if.sv
// request vector and winner between sequencer and priority selector
interface irq_sel_if;
    logic [15:0] req;
    logic [3:0] idx;
    logic hit;
    modport arb (input req, output idx, output hit);
    modport seq (output req, input idx, input hit);
endinterface

// ### verilog/irq_priority_sel.sv
// fixed priority selector, lowest index wins
module irq_priority_sel (
    irq_sel_if.arb sel_if
);
    always_comb begin
        sel_if.idx = 4'h0;
        sel_if.hit = 1'b0;
        for (int i = 15; i >= 1; i--) begin
            if (sel_if.req[i]) begin
                sel_if.idx = 4'(i); // RULE21
                sel_if.hit = 1'b1;
            end
        end
    end
endmodule

// ### verilog/interrupt_accept_return_sequencer.sv
// interrupt acceptance, return and address error sequencer
// Function
// [RULE1] acceptance clears master enable
// [RULE2] pseudo non-maskable acceptance blocks all requests
// [RULE3] clear only the accepted source's latch
// [RULE4] push pc and psw, sp minus three
// [RULE5] load entry address from vector table
// [RULE6] no maskable acceptance while master enable low
// [RULE7] software sets enable for nesting
// [RULE8] ext zero gated by pin select and master enable, not by an enable flag
// [RULE9] only pc and psw saved
// [RULE10] returns restore bank select via psw
// [RULE11] maskable return pops, sp plus three, enables
// [RULE12] non-maskable return restores enable conditionally
// [RULE13] sample requests at last instruction cycle
// [RULE14] soft trap accepted at once, top priority
// [RULE15] soft trap during pseudo nmi is nop
// [RULE16] unmapped fetch returns ff byte
// [RULE17] ram or sfr fetch raises trap reset
// [RULE18] test range fetch never returns ff
// [RULE19] acceptance takes eight machine cycles
// [RULE20] pseudo non-maskable sources never nest
// [RULE21] highest fixed priority accepted first
// [RULE22] stack: pcl lowest, pch, psw highest
// [RULE23] vector entry low byte first
module interrupt_accept_return_sequencer
    import irq_seq_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // instruction core
    input wire logic instr_last_cycle_i,
    input wire logic soft_trap_instr_i,
    input wire logic maskable_return_instr_i,
    input wire logic nonmaskable_return_instr_i,
    input wire logic ei_i,
    input wire logic di_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] psw_i,
    input wire logic [15:0] sp_i,
    output logic seq_busy_o,
    output logic [15:0] pc_o,
    output logic pc_load_o,
    output logic [7:0] program_status_word_o,
    output logic psw_load_o,
    output logic [15:0] sp_o,
    output logic sp_load_o,
    output logic [RBS_W-1:0] register_bank_select_o,
    output logic master_irq_enable_o,
    // stack and vector memory
    output logic [15:0] bus_addr_o,
    output logic [7:0] bus_wdata_o,
    output logic bus_we_o,
    output logic bus_re_o,
    input wire logic [7:0] bus_rdata_i,
    // interrupt controller
    input wire logic [15:2] pending_request_latch_i,
    input wire logic [15:4] source_enable_flag_i,
    input wire logic ext_zero_pin_select_i,
    output logic [15:2] latch_clr_o,
    // instruction fetch
    input wire logic fetch_req_i,
    input wire logic [15:0] fetch_addr_i,
    input wire logic [7:0] imem_rdata_i,
    output logic [7:0] fetch_data_o,
    output logic fetch_valid_o,
    output logic addr_trap_o
);

    // ****************************************
    // eligibility
    // ****************************************
    function automatic logic [15:0] req_vec(
        input logic [15:2] pend,
        input logic [15:4] ef,
        input logic master_irq_enable,
        input logic ext_zero_pin_select,
        input logic pnmi,
        input logic soft_trap_instr);
        logic [15:0] r;
        r = 16'h0000;
        if (!pnmi) begin // RULE2 RULE20
            r[1] = soft_trap_instr; // RULE14
            r[2] = pend[2];
            r[3] = master_irq_enable & ext_zero_pin_select & pend[3]; // RULE8
            r[15:4] = pend[15:4] & ef & {12{master_irq_enable}}; // RULE6
        end
        return r;
    endfunction

    seq_state_t state_q;
    logic imf_q, pnmi_q, imf_saved_q, dis_seen_q, ret_nmi_q;
    logic [3:0] src_q;
    logic [15:0] sp_q, ret_pc_q, rpc_q;
    logic [7:0] psw_q;
    logic ret_start, ret_end, sample, take, imf_eff, pnmi_eff;
    logic ret_imf;
    logic [15:0] ctx_pc, ctx_sp, clr_vec;
    logic [7:0] ctx_psw;

    irq_sel_if sel();
    irq_priority_sel u_sel (
        .sel_if (sel)
    );

    always_comb begin
        ret_start = (state_q == ST_IDLE)
            && (maskable_return_instr_i || nonmaskable_return_instr_i);
        ret_end = (state_q == ST_RPSW);
        ret_imf = ret_nmi_q ? (imf_saved_q && !dis_seen_q) : 1'b1; // RULE12
        imf_eff = ret_end ? ret_imf : imf_q;
        pnmi_eff = (ret_end && ret_nmi_q) ? 1'b0 : pnmi_q;
        // RULE13
        sample = ret_end || ((state_q == ST_IDLE) && !ret_start
            && (instr_last_cycle_i || soft_trap_instr_i));
        sel.req = req_vec(pending_request_latch_i, source_enable_flag_i,
            imf_eff, ext_zero_pin_select_i, pnmi_eff,
            (state_q == ST_IDLE) && soft_trap_instr_i); // RULE15
        take = sample && sel.hit;
        ctx_pc = ret_end ? rpc_q : pc_i;
        ctx_psw = ret_end ? bus_rdata_i : psw_i;
        ctx_sp = ret_end ? (sp_q + SP_STEP3) : sp_i;
        clr_vec = 16'h0001 << sel.idx;
    end

    // ****************************************
    // master enable and pseudo nmi tracking
    // ****************************************
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            imf_q <= 1'b0;
        end else if (take) begin
            imf_q <= 1'b0; // RULE1
        end else if (ret_end) begin
            imf_q <= ret_imf; // RULE11 RULE12
        end else if (di_i) begin
            imf_q <= 1'b0;
        end else if (ei_i) begin
            imf_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pnmi_q <= 1'b0;
            imf_saved_q <= 1'b0;
            dis_seen_q <= 1'b0;
        end else if (take && (sel.idx <= SRC_WDT)) begin
            pnmi_q <= 1'b1; // RULE2
            imf_saved_q <= imf_eff; // RULE12
            dis_seen_q <= 1'b0;
        end else if (ret_end && ret_nmi_q) begin
            pnmi_q <= 1'b0;
        end else if (pnmi_q && di_i) begin
            dis_seen_q <= 1'b1; // RULE12
        end
    end

    // ****************************************
    // context capture and latch clear
    // ****************************************
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            src_q <= 4'h0;
            sp_q <= 16'h0000;
            ret_pc_q <= 16'h0000;
            psw_q <= 8'h00;
            ret_nmi_q <= 1'b0;
            latch_clr_o <= 14'h0000;
        end else begin
            latch_clr_o <= take ? clr_vec[15:2] : 14'h0000; // RULE3
            if (take) begin
                src_q <= sel.idx;
                sp_q <= ctx_sp;
                ret_pc_q <= ctx_pc; // RULE9
                psw_q <= ctx_psw;
            end else if (ret_start) begin
                sp_q <= sp_i;
                ret_nmi_q <= nonmaskable_return_instr_i;
            end
        end
    end

    // ****************************************
    // accept and return sequence
    // ****************************************
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            rpc_q <= 16'h0000;
            bus_addr_o <= 16'h0000;
            bus_wdata_o <= 8'h00;
            bus_we_o <= 1'b0;
            bus_re_o <= 1'b0;
            pc_o <= 16'h0000;
            pc_load_o <= 1'b0;
            program_status_word_o <= 8'h00;
            psw_load_o <= 1'b0;
            sp_o <= 16'h0000;
            sp_load_o <= 1'b0;
        end else begin
            bus_we_o <= 1'b0;
            bus_re_o <= 1'b0;
            pc_load_o <= 1'b0;
            psw_load_o <= 1'b0;
            sp_load_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (ret_start) begin
                        state_q <= ST_RPCL;
                        bus_re_o <= 1'b1;
                        bus_addr_o <= sp_i + SP_STEP1;
                    end else if (take) begin
                        state_q <= ST_ACK; // RULE19
                    end
                end
                ST_ACK: state_q <= ST_GAP;
                ST_GAP: begin
                    state_q <= ST_PSW;
                    bus_we_o <= 1'b1; // RULE4 RULE22
                    bus_addr_o <= sp_q;
                    bus_wdata_o <= psw_q;
                end
                ST_PSW: begin
                    state_q <= ST_PCH;
                    bus_we_o <= 1'b1; // RULE22
                    bus_addr_o <= sp_q - SP_STEP1;
                    bus_wdata_o <= ret_pc_q[15:8];
                end
                ST_PCH: begin
                    state_q <= ST_PCL;
                    bus_we_o <= 1'b1; // RULE22
                    bus_addr_o <= sp_q - SP_STEP2;
                    bus_wdata_o <= ret_pc_q[7:0];
                end
                ST_PCL: begin
                    state_q <= ST_VLO;
                    bus_re_o <= 1'b1; // RULE23
                    bus_addr_o <= vec_addr(src_q);
                end
                ST_VLO: begin
                    state_q <= ST_VHI;
                    rpc_q[7:0] <= bus_rdata_i;
                    bus_re_o <= 1'b1;
                    bus_addr_o <= vec_addr(src_q) + SP_STEP1;
                end
                ST_VHI: begin
                    state_q <= ST_JUMP;
                    pc_o <= {bus_rdata_i, rpc_q[7:0]}; // RULE5
                    pc_load_o <= 1'b1;
                    sp_o <= sp_q - SP_STEP3; // RULE4
                    sp_load_o <= 1'b1;
                end
                ST_JUMP: state_q <= ST_IDLE;
                ST_RPCL: begin
                    state_q <= ST_RPCH;
                    rpc_q[7:0] <= bus_rdata_i;
                    bus_re_o <= 1'b1;
                    bus_addr_o <= sp_q + SP_STEP2;
                end
                ST_RPCH: begin
                    state_q <= ST_RPSW;
                    rpc_q[15:8] <= bus_rdata_i;
                    bus_re_o <= 1'b1;
                    bus_addr_o <= sp_q + SP_STEP3;
                end
                ST_RPSW: begin
                    state_q <= take ? ST_ACK : ST_IDLE; // RULE13
                    pc_o <= rpc_q; // RULE11
                    pc_load_o <= 1'b1;
                    program_status_word_o <= bus_rdata_i; // RULE10
                    psw_load_o <= 1'b1;
                    sp_o <= sp_q + SP_STEP3;
                    sp_load_o <= 1'b1;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // instruction fetch address check
    // ****************************************
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            fetch_data_o <= 8'h00;
            fetch_valid_o <= 1'b0;
            addr_trap_o <= 1'b0;
        end else begin
            addr_trap_o <= fetch_req_i
                && (fetch_addr_i <= RAM_SFR_END); // RULE17
            fetch_valid_o <= fetch_req_i
                && (fetch_addr_i > RAM_SFR_END);
            if ((fetch_addr_i >= ROM_BASE) || ((fetch_addr_i >= TEST_LO)
                && (fetch_addr_i <= TEST_HI))) begin
                fetch_data_o <= imem_rdata_i; // RULE18
            end else begin
                fetch_data_o <= FILL_BYTE; // RULE16
            end
        end
    end

    always_comb begin
        seq_busy_o = (state_q != ST_IDLE);
        master_irq_enable_o = imf_q;
        register_bank_select_o = program_status_word_o[RBS_LSB+:RBS_W];
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking dc @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    AST_IMF_CLR: assert property (take |=> !master_irq_enable_o) // RULE1
        else $error("master enable not cleared on acceptance");
    AST_PNMI_BLOCK: assert property ( // RULE2
        (pnmi_q && state_q == ST_IDLE) |-> !take)
        else $error("request taken during pseudo nmi service");
    AST_LATCH: assert property ( // RULE3
        take |=> latch_clr_o == $past(clr_vec[15:2]) ##1 latch_clr_o == 0)
        else $error("wrong latch cleared");
    AST_PUSH_PSW: assert property ( // RULE4
        state_q == ST_PSW |-> bus_we_o && bus_addr_o == sp_q
        && bus_wdata_o == psw_q)
        else $error("status word push wrong");
    AST_PCL: assert property ( // RULE22
        state_q == ST_PCL |-> bus_addr_o == sp_q - SP_STEP2
        && bus_wdata_o == ret_pc_q[7:0])
        else $error("pc low push wrong");
    AST_SP3: assert property ( // RULE4
        state_q == ST_JUMP |-> sp_load_o && sp_o == sp_q - SP_STEP3)
        else $error("stack pointer not lowered by three");
    AST_VEC: assert property ( // RULE23
        state_q == ST_VLO |-> bus_re_o && bus_addr_o == vec_addr(src_q))
        else $error("vector low read wrong");
    AST_ENTRY: assert property ( // RULE5
        state_q == ST_VHI |=> pc_load_o
        && pc_o == {$past(bus_rdata_i), rpc_q[7:0]})
        else $error("entry address not loaded");
    AST_LEN: assert property ( // RULE19
        take |=> state_q == ST_ACK ##7 state_q == ST_JUMP)
        else $error("acceptance not eight cycles");
    AST_MASK: assert property ( // RULE6
        (take && !imf_eff) |-> sel.idx < SRC_EXT_IRQ_ZERO)
        else $error("maskable taken with enable low");
    AST_SWI_TOP: assert property ( // RULE14
        (state_q == ST_IDLE && soft_trap_instr_i && !pnmi_q && !ret_start)
        |-> take && sel.idx == SRC_SWI)
        else $error("soft trap not accepted first");
    AST_SWI_NOP: assert property ( // RULE15
        (state_q == ST_IDLE && soft_trap_instr_i && pnmi_q)
        |=> state_q != ST_ACK)
        else $error("soft trap raised during pseudo nmi");
    AST_RET_SP: assert property ( // RULE11
        ret_end |=> sp_load_o && sp_o == $past(sp_q) + SP_STEP3)
        else $error("return stack pointer wrong");
    AST_MASKABLE_RETURN_INSTR_IMF: assert property ( // RULE11
        (ret_end && !ret_nmi_q && !take) |=> master_irq_enable_o)
        else $error("maskable return left enable low");
    AST_NONMASKABLE_RETURN_INSTR_IMF: assert property ( // RULE12
        (ret_end && ret_nmi_q && !imf_saved_q) |=> !master_irq_enable_o)
        else $error("non-maskable return set enable");
    AST_TRAP: assert property ( // RULE17
        (fetch_req_i && fetch_addr_i <= RAM_SFR_END)
        |=> addr_trap_o && !fetch_valid_o)
        else $error("no trap on ram fetch");
    AST_FILL: assert property ( // RULE16
        (fetch_req_i && fetch_addr_i > TEST_HI && fetch_addr_i < ROM_BASE)
        |=> fetch_data_o == FILL_BYTE)
        else $error("unmapped fetch not ff");
    AST_TEST: assert property ( // RULE18
        (fetch_req_i && fetch_addr_i >= TEST_LO && fetch_addr_i <= TEST_HI)
        |=> fetch_data_o == $past(imem_rdata_i))
        else $error("test range fetch filled");

    COV_TAKE: cover property (state_q == ST_IDLE && take);
    COV_BACK: cover property (ret_end && take);
    COV_NOP: cover property (soft_trap_instr_i && pnmi_q);
    COV_TRAP: cover property (addr_trap_o);

endmodule

// ### tb/irq_core_model.sv
// far-side model: stack and vector memory plus pending latches
module irq_core_model (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // memory bus
    input wire logic [15:0] bus_addr_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic bus_we_i,
    input wire logic bus_re_i,
    output logic [7:0] bus_rdata_o,
    // request latches
    input wire logic [15:2] latch_clr_i,
    input wire logic [15:2] set_req_i,
    input wire logic [15:2] drop_req_i,
    output logic [15:2] pend_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // memory
    // ****************************************
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;

    // same-cycle read; released bus shows inverse of last byte
    assign bus_rdata_o = bus_re_i ? mem[bus_addr_i] : ~last_q;

    always @(posedge clk_sys_i) begin
        if (bus_we_i) mem[bus_addr_i] <= bus_wdata_i;
        if (bus_re_i) last_q <= mem[bus_addr_i];
    end

    // ****************************************
    // latches
    // ****************************************
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) pend_o <= '0;
        else pend_o <= (pend_o & ~latch_clr_i & ~drop_req_i) | set_req_i;
    end
endmodule

// ### tb/interrupt_accept_return_sequencer_test.sv
// self-checking bench for the interrupt sequencer
module interrupt_accept_return_sequencer_test import irq_seq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // signals
    // ****************************************
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [5:0] ctl = '0; // di ei nret mret soft last
    logic [15:0] pc_i = 16'h1234;
    logic [7:0] psw_i = 8'ha7;
    logic [15:0] sp_i = 16'h043f;
    logic [15:4] ef = '0;
    logic pinsel = 1'b0;
    logic fetch_req = 1'b0;
    logic [15:0] fetch_addr = '0;
    logic [15:2] set_req = '0;
    logic [15:2] drop_req = '0;
    logic seq_busy_o, pc_load_o, psw_load_o, sp_load_o, imf_o;
    logic [15:0] pc_o, sp_o, bus_addr;
    logic [7:0] psw_o, bus_wdata, bus_rdata, fetch_data_o;
    logic [RBS_W-1:0] rbs_o;
    logic bus_we, bus_re, fetch_valid_o, addr_trap_o;
    logic [15:2] pend, latch_clr;
    int num_errors = 0;
    int n_compared = 0;

    always #10 clk_sys_i = ~clk_sys_i;

    interrupt_accept_return_sequencer dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .instr_last_cycle_i(ctl[0]), .soft_trap_instr_i(ctl[1]),
        .maskable_return_instr_i(ctl[2]),
        .nonmaskable_return_instr_i(ctl[3]),
        .ei_i(ctl[4]), .di_i(ctl[5]),
        .pc_i(pc_i), .psw_i(psw_i), .sp_i(sp_i),
        .seq_busy_o(seq_busy_o), .pc_o(pc_o), .pc_load_o(pc_load_o),
        .program_status_word_o(psw_o), .psw_load_o(psw_load_o),
        .sp_o(sp_o), .sp_load_o(sp_load_o),
        .register_bank_select_o(rbs_o), .master_irq_enable_o(imf_o),
        .bus_addr_o(bus_addr), .bus_wdata_o(bus_wdata), .bus_we_o(bus_we),
        .bus_re_o(bus_re), .bus_rdata_i(bus_rdata),
        .pending_request_latch_i(pend), .source_enable_flag_i(ef),
        .ext_zero_pin_select_i(pinsel), .latch_clr_o(latch_clr),
        .fetch_req_i(fetch_req), .fetch_addr_i(fetch_addr),
        .imem_rdata_i(8'h3c), .fetch_data_o(fetch_data_o),
        .fetch_valid_o(fetch_valid_o), .addr_trap_o(addr_trap_o)
    );

    irq_core_model partner (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .bus_addr_i(bus_addr), .bus_wdata_i(bus_wdata), .bus_we_i(bus_we),
        .bus_re_i(bus_re), .bus_rdata_o(bus_rdata),
        .latch_clr_i(latch_clr), .set_req_i(set_req),
        .drop_req_i(drop_req), .pend_o(pend)
    );

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    task automatic end_sim();
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    function automatic logic [15:2] bit_of(input int i);
        logic [15:2] v;
        v = '0;
        v[i] = 1'b1;
        return v;
    endfunction

    function automatic logic [15:0] entry(input int s);
        return {8'ha0 + 8'(s), 8'h10 + 8'(s)};
    endfunction

    task automatic pulse(input int k);
        @(posedge clk_sys_i) ctl[k] <= 1'b1;
        @(posedge clk_sys_i) ctl <= '0;
    endtask

    task automatic latch(input logic [15:2] s, input logic [15:2] d);
        @(posedge clk_sys_i) begin
            set_req <= s;
            drop_req <= d;
        end
        @(posedge clk_sys_i) begin
            set_req <= '0;
            drop_req <= '0;
        end
    endtask

    task automatic wait_load(output int n);
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (pc_load_o !== 1'b1 && n < 20);
    endtask

    task automatic accept_chk(input int src, input logic [15:2] exp_pend);
        int n;
        wait_load(n);
        chk(16'(n), 16'h0008);
        chk(pc_o, entry(src));
        chk(sp_o, 16'h043c);
        chk({psw_load_o, sp_load_o}, 16'h0001);
        chk({partner.mem[16'h043d], partner.mem[16'h043e]}, 16'h3412);
        chk({8'h00, partner.mem[16'h043f]}, 16'h00a7);
        chk({15'h0, imf_o}, 16'h0000);
        chk({pend, 2'b00}, {exp_pend, 2'b00});
    endtask

    task automatic ret_chk(input int k, input logic exp_imf);
        int n;
        @(posedge clk_sys_i) begin
            pc_i <= 16'h0000;
            psw_i <= 8'h00;
            sp_i <= 16'h043c;
        end
        pulse(k);
        wait_load(n);
        chk(pc_o, 16'h1234);
        chk({8'h00, psw_o}, 16'h00a7);
        chk(16'(rbs_o), 16'h0007);
        chk(sp_o, 16'h043f);
        chk({psw_load_o, sp_load_o}, 16'h0003);
        @(negedge clk_sys_i);
        if (exp_imf !== 1'bx) chk({15'h0, imf_o}, {15'h0, exp_imf});
        @(posedge clk_sys_i) begin
            pc_i <= 16'h1234;
            psw_i <= 8'ha7;
            sp_i <= 16'h043f;
        end
    endtask

    task automatic blocked_chk(input logic [15:2] exp_pend);
        int busy_n;
        busy_n = 0;
        repeat (12) begin
            @(negedge clk_sys_i);
            if (seq_busy_o !== 1'b0) busy_n++;
        end
        chk(16'(busy_n), 16'h0000);
        chk({pend, 2'b00}, {exp_pend, 2'b00});
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic scn_priority();
        @(posedge clk_sys_i) ef <= '1;
        pulse(4);
        latch(bit_of(5) | bit_of(9), '0);
        pulse(0);
        accept_chk(5, bit_of(9));
        latch('0, bit_of(9));
        ret_chk(2, 1'b1);
    endtask

    task automatic scn_masked();
        pulse(5);
        latch(bit_of(4), '0);
        pulse(0);
        blocked_chk(bit_of(4));
        pulse(4);
        @(posedge clk_sys_i) ef <= '0;
        latch(bit_of(3), bit_of(4));
        pulse(0);
        blocked_chk(bit_of(3));
        @(posedge clk_sys_i) pinsel <= 1'b1;
        pulse(0);
        accept_chk(3, '0);
        ret_chk(2, 1'b1);
        @(posedge clk_sys_i) ef <= '1;
    endtask

    task automatic scn_soft();
        pulse(5);
        pulse(1);
        accept_chk(1, '0);
        pulse(4);
        latch(bit_of(2) | bit_of(5), '0);
        pulse(0);
        blocked_chk(bit_of(2) | bit_of(5));
        pulse(1);
        blocked_chk(bit_of(2) | bit_of(5));
        chk(sp_o, 16'h043c);
        latch('0, bit_of(2) | bit_of(5));
        ret_chk(3, 1'b0);
    endtask

    task automatic scn_chain();
        int n;
        pulse(4);
        latch(bit_of(2), '0);
        pulse(0);
        accept_chk(2, '0);
        latch(bit_of(6), '0);
        pulse(1);
        blocked_chk(bit_of(6));
        ret_chk(3, 1'bx);
        wait_load(n);
        chk(pc_o, entry(6));
        chk({pend, 2'b00}, 16'h0000);
        ret_chk(2, 1'b1);
    endtask

    task automatic scn_nmi_return();
        for (int d = 0; d < 2; d++) begin
            pulse(4);
            latch(bit_of(2), '0);
            pulse(0);
            accept_chk(2, '0);
            if (d == 1) pulse(5);
            ret_chk(3, d == 0);
        end
    endtask

    task automatic scn_fetch();
        logic [15:0] a [7];
        logic trap;
        logic [7:0] exp;
        a = '{16'h0000, 16'h083f, 16'h0840, 16'h1080, 16'h10ff, 16'h1100,
              16'h8000};
        for (int i = 0; i < 7; i++) begin
            trap = a[i] <= 16'h083f;
            exp = (a[i] >= 16'h8000 || (a[i] >= 16'h1080 && a[i] <= 16'h10ff))
                ? 8'h3c : 8'hff;
            @(posedge clk_sys_i) begin
                fetch_req <= 1'b1;
                fetch_addr <= a[i];
            end
            @(posedge clk_sys_i) fetch_req <= 1'b0;
            @(negedge clk_sys_i);
            chk({addr_trap_o, fetch_valid_o}, {trap, !trap});
            if (!trap) chk(16'(fetch_data_o), 16'(exp));
        end
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        for (int s = 1; s < 16; s++) begin
            partner.mem[16'hfffe - 16'(2 * s)] = 8'h10 + 8'(s);
            partner.mem[16'hffff - 16'(2 * s)] = 8'ha0 + 8'(s);
        end
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        scn_priority();
        scn_masked();
        scn_soft();
        scn_chain();
        scn_nmi_return();
        scn_fetch();
        end_sim();
    end

    initial begin
        #200000;
        num_errors++;
        end_sim();
    end
endmodule
